// *** src/channel_config_high_pkg.sv ***
// constants for the upper channel configuration word
package channel_config_high_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] CHANNEL_CONFIG_HIGH_OFFSET = 8'h9c;
  localparam logic [31:0] CHANNEL_CONFIG_HIGH_RESET = 32'h00000004;

  // ---------------------------------------------------------------
  // field layout
  // ---------------------------------------------------------------
  localparam int IF_W = 4;
  localparam int PROT_W = 3;
  localparam int DEST_IF_LSB = 11;
  localparam int SRC_IF_LSB = 7;
  localparam int PROT_LSB = 2;
  localparam int FF_MODE_BIT = 1;
  localparam int FW_MODE_BIT = 0;
  localparam int USED_BITS = 15;

  // ---------------------------------------------------------------
  // bus protection
  // ---------------------------------------------------------------
  // the channel never fetches opcodes, so every access is data
  localparam logic HPROT_DATA_ACCESS = 1'b1;
endpackage : channel_config_high_pkg

// *** src/channel_config_high.sv ***
// upper configuration word of one dma channel and its request gating
// Contract
// RULE1: destination field picks hardware handshake interface
// RULE2: source field picks hardware handshake interface
// RULE3: software maps each interface to one endpoint
// RULE4: protection bits drive hprot three to one
// RULE5: hprot bit zero always high
// RULE6: reset word four, privileged data access
// RULE7: mode zero services at one transfer
// RULE8: mode one waits half fifo depth
// RULE9: flow mode zero services source immediately, prefetches
// RULE10: flow mode one holds source until destination
// RULE11: select bit chooses hardware or software handshake
// RULE12: reserved bits read zero, writes ignored
`timescale 1ns/1ps
`default_nettype none
module channel_config_high
  import channel_config_high_pkg::*;
#(
  parameter int FIFO_DEPTH = 16,
  parameter int CNT_W = 5,
  parameter int NUM_IF = 16
) (
  // clock, reset and enable
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_en,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // handshake selects from the lower configuration word
  input wire logic source_sw_handshake,
  input wire logic dest_sw_handshake,
  // transfer type
  input wire logic source_is_memory,
  input wire logic dest_is_memory,
  input wire logic dest_is_flow_controller,
  // transaction requests
  input wire logic [NUM_IF-1:0] hw_request,
  input wire logic sw_source_request,
  input wire logic sw_dest_request,
  // fifo occupancy in items of the programmed transfer width
  input wire logic [CNT_W-1:0] fifo_data,
  input wire logic [CNT_W-1:0] fifo_space,
  input wire logic burst_end,
  input wire logic block_end,
  // to the bus master and the channel engine
  output logic [3:0] hprot,
  output logic [IF_W-1:0] source_handshake_select,
  output logic [IF_W-1:0] dest_handshake_select,
  output logic source_service,
  output logic dest_service,
  output logic prefetch_enable
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [IF_W-1:0] dest_if;
    logic [IF_W-1:0] src_if;
    logic [PROT_W-1:0] prot;
    logic ff_mode;
    logic fw_mode;
    logic [31:0] rdata;
    logic [3:0] hprot;
    logic src_service;
    logic dst_service;
    logic prefetch;
    logic dst_seen;
  } state_t;

  localparam logic [CNT_W-1:0] HALF_DEPTH = CNT_W'(FIFO_DEPTH / 2);

  localparam state_t RESET_STATE = '{
    dest_if: CHANNEL_CONFIG_HIGH_RESET[DEST_IF_LSB +: IF_W],
    src_if: CHANNEL_CONFIG_HIGH_RESET[SRC_IF_LSB +: IF_W],
    prot: CHANNEL_CONFIG_HIGH_RESET[PROT_LSB +: PROT_W],
    ff_mode: CHANNEL_CONFIG_HIGH_RESET[FF_MODE_BIT],
    fw_mode: CHANNEL_CONFIG_HIGH_RESET[FW_MODE_BIT],
    rdata: 32'h00000000,
    hprot: {CHANNEL_CONFIG_HIGH_RESET[PROT_LSB +: PROT_W],
            HPROT_DATA_ACCESS},
    src_service: 1'b0,
    dst_service: 1'b0,
    prefetch: 1'b1,
    dst_seen: 1'b0
  };

  state_t cur;
  state_t next_cur;

  logic hit;
  logic src_raw;
  logic dst_raw;
  logic src_room;
  logic dst_room;
  logic hold_source;
  logic src_gate;
  logic any_end;
  logic [31:0] readback;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_cur = cur;
    hit = (reg_addr == CHANNEL_CONFIG_HIGH_OFFSET);
    any_end = burst_end | block_end;

    // only the documented fields come back, the rest read zero
    readback = 32'h00000000;
    readback[DEST_IF_LSB +: IF_W] = cur.dest_if; // RULE12
    readback[SRC_IF_LSB +: IF_W] = cur.src_if;
    readback[PROT_LSB +: PROT_W] = cur.prot;
    readback[FF_MODE_BIT] = cur.ff_mode;
    readback[FW_MODE_BIT] = cur.fw_mode;

    // a memory endpoint is always ready, its select bit is unused
    if (source_is_memory) begin
      src_raw = 1'b1;
    end else if (source_sw_handshake) begin
      src_raw = sw_source_request; // RULE11
    end else begin
      src_raw = hw_request[cur.src_if]; // RULE2
    end
    if (dest_is_memory) begin
      dst_raw = 1'b1;
    end else if (dest_sw_handshake) begin
      dst_raw = sw_dest_request; // RULE11
    end else begin
      dst_raw = hw_request[cur.dest_if]; // RULE1
    end

    // fifo threshold before a burst is serviced
    if (cur.ff_mode) begin
      src_room = (fifo_space > HALF_DEPTH) | any_end; // RULE8
      dst_room = (fifo_data >= HALF_DEPTH) | any_end; // RULE8
    end else begin
      src_room = (fifo_space != '0); // RULE7
      dst_room = (fifo_data != '0); // RULE7
    end

    // with the destination in charge of flow, mode one reads the
    // source only on demand and only with an empty fifo, so nothing
    // can be stranded when the destination ends the block
    hold_source = dest_is_flow_controller & cur.fw_mode;
    if (hold_source) begin
      src_gate = (cur.dst_seen | dst_raw) & (fifo_data == '0); // RULE10
    end else begin
      src_gate = 1'b1; // RULE9
    end

    if (!hold_source) begin
      next_cur.dst_seen = 1'b0;
    end else if (dst_raw) begin
      next_cur.dst_seen = 1'b1;
    end else if (block_end) begin
      next_cur.dst_seen = 1'b0;
    end

    next_cur.src_service = src_raw & src_room & src_gate;
    next_cur.dst_service = dst_raw & dst_room;
    next_cur.prefetch = ~hold_source; // RULE9
    next_cur.hprot = {cur.prot, HPROT_DATA_ACCESS}; // RULE4 RULE5

    if (reg_wr && hit) begin
      // reserved positions are dropped on the floor
      next_cur.dest_if = reg_wdata[DEST_IF_LSB +: IF_W]; // RULE12
      next_cur.src_if = reg_wdata[SRC_IF_LSB +: IF_W];
      next_cur.prot = reg_wdata[PROT_LSB +: PROT_W];
      next_cur.ff_mode = reg_wdata[FF_MODE_BIT];
      next_cur.fw_mode = reg_wdata[FW_MODE_BIT];
    end

    // unmapped reads answer zero
    next_cur.rdata = 32'h00000000;
    if (reg_rd && hit) begin
      next_cur.rdata = readback;
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cur <= RESET_STATE; // RULE6
    end else if (clk_en) begin
      cur <= next_cur;
    end
  end

  assign reg_rdata = cur.rdata;
  assign hprot = cur.hprot;
  assign source_handshake_select = cur.src_if;
  assign dest_handshake_select = cur.dest_if;
  assign source_service = cur.src_service;
  assign dest_service = cur.dst_service;
  assign prefetch_enable = cur.prefetch;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  data_access_a: assert property ( // RULE5
    @(posedge clk_sys) disable iff (rst) hprot[0] == 1'b1)
    else $error("hprot bit zero not high");

  prot_mapping_a: assert property ( // RULE4
    @(posedge clk_sys) disable iff (rst)
    $past(clk_en) |-> hprot[3:1] == $past(cur.prot))
    else $error("hprot does not follow protection bits");

  reset_prot_a: assert property ( // RULE6
    @(posedge clk_sys) disable iff (rst)
    $past(rst) |-> hprot == 4'h3 && cur.prot == 3'h1)
    else $error("protection reset value wrong");

  reserved_zero_a: assert property ( // RULE12
    @(posedge clk_sys) disable iff (rst)
    $past(clk_en) && $past(reg_rd) |->
      reg_rdata[31:USED_BITS] == '0 && reg_rdata[6:5] == 2'h0)
    else $error("reserved bits read nonzero");

  write_read_a: assert property ( // RULE12
    @(posedge clk_sys) disable iff (rst)
    clk_en && reg_wr && hit ##1 clk_en && reg_rd && hit && !reg_wr
    |=> reg_rdata == ($past(reg_wdata, 2) & 32'h00007f9f))
    else $error("readback does not match write");

  src_hw_a: assert property ( // RULE2
    @(posedge clk_sys) disable iff (rst)
    $past(clk_en) && source_service && !$past(source_is_memory)
      && !$past(source_sw_handshake)
    |-> $past(hw_request[cur.src_if]))
    else $error("source served without its hardware request");

  dst_hw_a: assert property ( // RULE1
    @(posedge clk_sys) disable iff (rst)
    $past(clk_en) && dest_service && !$past(dest_is_memory)
      && !$past(dest_sw_handshake)
    |-> $past(hw_request[cur.dest_if]))
    else $error("destination served without its hardware request");

  sw_select_a: assert property ( // RULE11
    @(posedge clk_sys) disable iff (rst)
    $past(clk_en) && source_service && !$past(source_is_memory)
      && $past(source_sw_handshake)
    |-> $past(sw_source_request))
    else $error("source served without software request");

  single_xfer_a: assert property ( // RULE7
    @(posedge clk_sys) disable iff (rst)
    $past(clk_en) && !$past(cur.ff_mode) && dest_service
    |-> $past(fifo_data) != '0)
    else $error("destination served from empty fifo");

  half_depth_a: assert property ( // RULE8
    @(posedge clk_sys) disable iff (rst)
    $past(clk_en) && $past(cur.ff_mode) && source_service
    |-> $past(fifo_space) > HALF_DEPTH || $past(burst_end)
      || $past(block_end))
    else $error("source served below half depth space");

  prefetch_mode_a: assert property ( // RULE9
    @(posedge clk_sys) disable iff (rst)
    $past(clk_en) |-> prefetch_enable ==
      !($past(dest_is_flow_controller) && $past(cur.fw_mode)))
    else $error("prefetch enable wrong");

  hold_source_a: assert property ( // RULE10
    @(posedge clk_sys) disable iff (rst)
    $past(clk_en) && source_service && $past(dest_is_flow_controller)
      && $past(cur.fw_mode)
    |-> $past(fifo_data) == '0)
    else $error("source served ahead of destination");

  dest_first_a: assert property ( // RULE10
    @(posedge clk_sys) disable iff (rst)
    $past(clk_en) && source_service && $past(hold_source)
    |-> $past(cur.dst_seen) || $past(dst_raw))
    else $error("source served before any destination request");

  dst_sw_select_a: assert property ( // RULE11
    @(posedge clk_sys) disable iff (rst)
    $past(clk_en) && dest_service && !$past(dest_is_memory)
      && $past(dest_sw_handshake)
    |-> $past(sw_dest_request))
    else $error("destination served without software request");

  src_single_a: assert property ( // RULE7
    @(posedge clk_sys) disable iff (rst)
    $past(clk_en) && !$past(cur.ff_mode) && source_service
    |-> $past(fifo_space) != '0)
    else $error("source served into full fifo");

  dst_half_a: assert property ( // RULE8
    @(posedge clk_sys) disable iff (rst)
    $past(clk_en) && $past(cur.ff_mode) && dest_service
    |-> $past(fifo_data) >= HALF_DEPTH || $past(burst_end)
      || $past(block_end))
    else $error("destination served below half depth data");

  select_write_a: assert property ( // RULE1
    @(posedge clk_sys) disable iff (rst)
    $past(clk_en && reg_wr && hit) |->
      dest_handshake_select == $past(reg_wdata[DEST_IF_LSB +: IF_W])
      && source_handshake_select == $past(reg_wdata[SRC_IF_LSB +: IF_W]))
    else $error("handshake selects do not follow write");

endmodule : channel_config_high
`default_nettype wire

// *** tb/channel_config_high_peers.sv ***
// model of the peripherals behind the hardware handshake request lines
`timescale 1ns/1ps
`default_nettype none
module channel_config_high_peers (
  // clock
  input wire logic clk_sys,
  // interfaces programmed for each end and whether that end wants service
  input wire logic [3:0] source_if,
  input wire logic [3:0] dest_if,
  input wire logic source_want,
  input wire logic dest_want,
  // request lines, one per handshake interface
  output logic [15:0] hw_request
);
  logic [15:0] lines;
  // lines with no peripheral toggle at random so a wrong select shows up
  always @(posedge clk_sys) begin
    lines = 16'($urandom);
    lines[source_if] = source_want;
    // one peripheral per interface: on a clash the shared line follows the source
    if (dest_if != source_if) lines[dest_if] = dest_want;
    hw_request <= lines;
  end
endmodule : channel_config_high_peers
`default_nettype wire

// *** tb/channel_config_high_tb_top.sv ***
// self-checking bench for the upper channel configuration word
`timescale 1ns/1ps
`default_nettype none
module channel_config_high_tb_top;
  import channel_config_high_pkg::*;
  typedef struct packed {
    logic [31:0] rdata;
    logic [3:0] hprot;
    logic [3:0] ssel;
    logic [3:0] dsel;
    logic [2:0] svc;
  } exp_t;
  // ---------------------------------------------------------------
  // stimulus and observed signals
  // ---------------------------------------------------------------
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  // sw source, sw dest, source mem, dest mem, dest flow controller
  logic [4:0] mode = '0;
  // sw source req, sw dest req, burst end, block end
  logic [3:0] misc = '0;
  logic [1:0] want = '0;
  logic [7:0] peer_if = '0;
  logic [4:0] fifo_data = '0;
  logic [4:0] fifo_space = '0;
  logic [15:0] hw_request;
  logic [31:0] reg_rdata;
  logic [3:0] hprot;
  logic [3:0] ssel;
  logic [3:0] dsel;
  logic ssvc;
  logic dsvc;
  logic pf;
  logic [31:0] cfg = 32'h00000004;
  logic seen = 1'b0;
  exp_t last;
  exp_t got;
  exp_t exp_q[$];
  int error_cnt = 0;
  int comparisons = 0;
  always #12.5 clk_sys = ~clk_sys;
  channel_config_high dut_u (.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .source_sw_handshake(mode[4]),
    .dest_sw_handshake(mode[3]), .source_is_memory(mode[2]),
    .dest_is_memory(mode[1]), .dest_is_flow_controller(mode[0]),
    .hw_request(hw_request), .sw_source_request(misc[3]),
    .sw_dest_request(misc[2]), .fifo_data(fifo_data),
    .fifo_space(fifo_space), .burst_end(misc[1]), .block_end(misc[0]),
    .hprot(hprot), .source_handshake_select(ssel),
    .dest_handshake_select(dsel), .source_service(ssvc),
    .dest_service(dsvc), .prefetch_enable(pf));
  channel_config_high_peers peers_u (.clk_sys(clk_sys),
    .source_if(peer_if[3:0]), .dest_if(peer_if[7:4]),
    .source_want(want[1]), .dest_want(want[0]), .hw_request(hw_request));
  // ---------------------------------------------------------------
  // checking
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] seen_v, input logic [31:0] exp_v);
    comparisons++;
    if (seen_v !== exp_v) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, seen_v, exp_v);
    end
  endtask : check
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out
  // expectation from the inputs this edge sampled, seen 1 ns after the same edge
  task automatic predict();
    exp_t e;
    logic sreq, dreq, sok, dok, hold, wr_hit;
    sreq = mode[2] | (mode[4] ? misc[3] : hw_request[cfg[10:7]]);
    dreq = mode[1] | (mode[3] ? misc[2] : hw_request[cfg[14:11]]);
    sok = cfg[1] ? (fifo_space > 5'd8 || misc[1] || misc[0])
                 : fifo_space != 5'd0;
    dok = cfg[1] ? (fifo_data >= 5'd8 || misc[1] || misc[0])
                 : fifo_data != 5'd0;
    hold = mode[0] & cfg[0];
    wr_hit = reg_wr && reg_addr == 8'h9c;
    e.rdata = (reg_rd && reg_addr == 8'h9c) ? cfg & 32'h00007f9f : '0;
    e.hprot = {cfg[4:2], 1'b1};
    e.svc = {sreq & sok & (!hold | ((seen | dreq) & fifo_data == 5'd0)),
             dreq & dok, !hold};
    if (!clk_en) e = last;
    else begin
      if (wr_hit) cfg = reg_wdata & 32'h00007f9f;
      // the selects are the fields themselves, so a write shows at once
      e.ssel = cfg[10:7];
      e.dsel = cfg[14:11];
      seen = hold & (dreq | (seen & !misc[0]));
    end
    last = e;
    exp_q.push_back(e);
  endtask : predict
  // the monitor pairs each settled output set with the oldest note
  always @(posedge clk_sys) begin
    #1;
    if (exp_q.size() != 0) begin
      got = exp_q.pop_front();
      check(reg_rdata, got.rdata);
      check(32'(hprot), 32'(got.hprot));
      check(32'({dsel, ssel}), 32'({got.dsel, got.ssel}));
      check(32'({ssvc, dsvc, pf}), 32'(got.svc));
    end
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [31:0] r;
    void'($urandom(32'hcdedaed8));
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    for (int i = 0; i < 4000; i++) begin
      @(posedge clk_sys);
      predict();
      r = $urandom;
      // the first access reads the word straight out of reset
      if (i == 0) r = 32'h000000fa;
      reg_wr <= r[2:0] == 3'd1;
      reg_rd <= r[2:0] == 3'd2;
      reg_addr <= r[3] ? 8'h9c : r[31:24];
      reg_wdata <= $urandom;
      clk_en <= r[7:4] != 4'h0;
      mode <= r[12:8];
      misc <= r[16:13];
      want <= r[18:17];
      fifo_data <= 5'($urandom_range(16));
      fifo_space <= 5'($urandom_range(16));
      peer_if <= {cfg[14:11], cfg[10:7]};
    end
    @(posedge clk_sys);
    #2;
    close_out();
  end
  // a hang is cut short at twice the expected run length
  initial begin
    #200000;
    error_cnt++;
    close_out();
  end
endmodule : channel_config_high_tb_top
`default_nettype wire
